// ===== logic/sil_pkg.sv
// Package: constants and carrier structs for the status indicator logic
package sil_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned SIL_CLK_HZ = 200_000_000;
  localparam int unsigned SIL_FLASH_HALF_MS = 250;
  localparam int unsigned SIL_BRIEF_MS = 500;
  localparam int unsigned SIL_FLASH_HALF_CYC = SIL_CLK_HZ / 1000 * SIL_FLASH_HALF_MS;
  localparam int unsigned SIL_BRIEF_CYC = SIL_CLK_HZ / 1000 * SIL_BRIEF_MS;
  localparam int unsigned SIL_CNT_W = 28;

  // ****************************************************************
  // Field layouts
  // ****************************************************************
  localparam int unsigned SIL_VEL_W = 16;
  localparam int unsigned SIL_RATE_W = 16;
  localparam logic [SIL_VEL_W-1:0] SIL_MINIMUM_VELOCITY_THRESHOLD_RST = 16'h0000;

  typedef enum logic [1:0] {
    SIL_LAMP_OFF = 2'h0,
    SIL_LAMP_GREEN = 2'h1,
    SIL_LAMP_YELLOW = 2'h3,
    SIL_LAMP_RED = 2'h2
  } sil_colour_e;

  typedef struct packed {
    logic signal_valid;
    logic quality_ok;
    logic moving;
    logic [SIL_VEL_W-1:0] velocity;
    logic [SIL_RATE_W-1:0] rate;
  } sil_meas_s;

  typedef struct packed {
    logic [SIL_VEL_W-1:0] minimum_velocity_threshold;
    logic rate_monitor_enable;
    logic [SIL_RATE_W-1:0] minimum_rate;
    logic limit_control_enable;
    logic [SIL_VEL_W-1:0] velocity_low;
    logic [SIL_VEL_W-1:0] velocity_high;
    logic [SIL_RATE_W-1:0] rate_low;
    logic [SIL_RATE_W-1:0] rate_high;
    logic auto_direction;
    logic set_backward;
  } sil_cfg_s;

  typedef struct packed {
    logic signal_green;
    logic signal_yellow;
    logic signal_red;
    logic busy_yellow;
    logic error_red;
    logic forward_green;
    logic backward_green;
  } sil_lamps_s;

endpackage : sil_pkg

// ===== logic/sil_status_indicator.sv
// Module: lamp and status output driver for the velocity instrument
`timescale 1ns/1ps

// Contract
// - Signal lamp green while object moves with sufficient signal quality.
// - Signal lamp yellow when signal usable but minimum velocity not reached.
// - Signal lamp red whenever neither green nor yellow condition holds.
// - With rate monitoring on, rate below minimum forces red.
// - With limit control on, velocity or rate out of range forces red.
// - Status output high exactly while signal lamp is green.
// - Busy lamp steady during commands, calibration, simulation, offline measurement.
// - Busy lamp flashes in standby, by command or external standby input.
// - Error lamp flashes steadily on fatal error, briefly on critical error.
// - During initialization signal and busy show yellow, error red.
// - Forward lamp green on set forward or detected forward motion; the code keeps it dark while initializing.
// - Backward lamp green on set backward or detected backward motion; the code keeps it dark while initializing.
module sil_status_indicator
  import sil_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire sil_meas_s meas,
  input wire sil_cfg_s cfg,
  input wire logic cmd_active,
  input wire logic calibrating,
  input wire logic simulating,
  input wire logic offline_measuring,
  input wire logic standby_cmd,
  input wire logic standby_pin,
  input wire logic fatal_error,
  input wire logic critical_error_pulse,
  input wire logic initializing,
  input wire logic motion_forward,
  input wire logic motion_backward,
  output sil_lamps_s lamps,
  output sil_colour_e signal_colour,
  output logic status_out
);

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  // The standby input is an external pin, so it passes two flops first
  logic standby_meta_q;
  logic standby_sync_q;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      standby_meta_q <= 1'b0;
      standby_sync_q <= 1'b0;
    end else begin
      standby_meta_q <= standby_pin;
      standby_sync_q <= standby_meta_q;
    end
  end

  // ****************************************************************
  // Signal lamp conditions
  // ****************************************************************
  wire rate_fail = cfg.rate_monitor_enable && (meas.rate < cfg.minimum_rate);
  wire vel_out = (meas.velocity < cfg.velocity_low) || (meas.velocity > cfg.velocity_high);
  wire rate_out = (meas.rate < cfg.rate_low) || (meas.rate > cfg.rate_high);
  wire limit_fail = cfg.limit_control_enable && (vel_out || rate_out);
  wire forced_red = rate_fail || limit_fail;
  wire below_minimum_velocity_threshold = meas.velocity < cfg.minimum_velocity_threshold;
  wire green_cond = meas.moving && meas.quality_ok && !below_minimum_velocity_threshold && !forced_red;
  wire yellow_cond = meas.signal_valid && below_minimum_velocity_threshold && !forced_red;

  // Green is tested before yellow so only one colour can ever win
  wire sil_colour_e colour_d = initializing ? SIL_LAMP_YELLOW :
                               green_cond ? SIL_LAMP_GREEN :
                               yellow_cond ? SIL_LAMP_YELLOW : SIL_LAMP_RED;

  // ****************************************************************
  // Flash timing
  // ****************************************************************
  // One shared flasher keeps busy and error lamps blinking in step
  logic [SIL_CNT_W-1:0] flash_cnt_q;
  logic flash_q;
  logic [SIL_CNT_W-1:0] brief_cnt_q;
  wire flash_wrap = flash_cnt_q == SIL_CNT_W'(SIL_FLASH_HALF_CYC - 1);
  wire brief_active = brief_cnt_q != '0;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      flash_cnt_q <= '0;
      flash_q <= 1'b0;
    end else begin
      flash_cnt_q <= flash_wrap ? '0 : flash_cnt_q + 1'b1;
      flash_q <= flash_wrap ? !flash_q : flash_q;
    end
  end

  // A new critical error restarts the brief window; set wins over expiry
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      brief_cnt_q <= '0;
    end else if (critical_error_pulse) begin
      brief_cnt_q <= SIL_CNT_W'(SIL_BRIEF_CYC);
    end else if (brief_active) begin
      brief_cnt_q <= brief_cnt_q - 1'b1;
    end
  end

  // ****************************************************************
  // Lamp decode
  // ****************************************************************
  wire standby = standby_cmd || standby_sync_q;
  wire busy_steady = cmd_active || calibrating || simulating || offline_measuring;
  wire busy_d = initializing || (standby ? flash_q : busy_steady);
  wire error_d = initializing || ((fatal_error || brief_active) && flash_q);
  // Direction lamps stay dark while initializing, so no stale direction shows
  wire fwd_d = !initializing && (cfg.auto_direction ? motion_forward : !cfg.set_backward);
  wire bwd_d = !initializing && (cfg.auto_direction ? motion_backward : cfg.set_backward);

  // ****************************************************************
  // Output registers
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      signal_colour <= SIL_LAMP_RED;
      status_out <= 1'b0;
      // Reset shows red on the lamp too, so lamp and colour never disagree
      lamps <= '{signal_red: 1'b1, default: 1'b0};
    end else begin
      signal_colour <= colour_d;
      status_out <= (colour_d == SIL_LAMP_GREEN);
      lamps.signal_green <= (colour_d == SIL_LAMP_GREEN);
      lamps.signal_yellow <= (colour_d == SIL_LAMP_YELLOW);
      lamps.signal_red <= (colour_d == SIL_LAMP_RED);
      lamps.busy_yellow <= busy_d;
      lamps.error_red <= error_d;
      lamps.forward_green <= fwd_d;
      lamps.backward_green <= bwd_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  status_green_a: assert property (status_out == (signal_colour == SIL_LAMP_GREEN))
    else $error("Status output disagrees with green lamp");
  one_colour_a: assert property ($onehot({lamps.signal_green, lamps.signal_yellow, lamps.signal_red}))
    else $error("Signal lamp shows other than one colour");
  green_cause_a: assert property (green_cond && !initializing |=> signal_colour == SIL_LAMP_GREEN)
    else $error("Green condition did not light green");
  yellow_cause_a: assert property (!green_cond && yellow_cond && !initializing
    |=> signal_colour == SIL_LAMP_YELLOW)
    else $error("Yellow condition did not light yellow");
  red_default_a: assert property (!green_cond && !yellow_cond && !initializing
    |=> signal_colour == SIL_LAMP_RED)
    else $error("Red not shown when no condition holds");
  rate_red_a: assert property (cfg.rate_monitor_enable && meas.rate < cfg.minimum_rate && !initializing
    |=> signal_colour == SIL_LAMP_RED)
    else $error("Low rate not shown red");
  limit_red_a: assert property (limit_fail && !initializing |=> lamps.signal_red)
    else $error("Limit violation not shown red");
  busy_steady_a: assert property (busy_steady && !standby && !initializing |=> lamps.busy_yellow)
    else $error("Busy lamp not lit during activity");
  standby_flash_a: assert property (standby && !initializing
    |=> lamps.busy_yellow == $past(flash_q))
    else $error("Busy lamp not following flash in standby");
  brief_error_a: assert property (critical_error_pulse |=> brief_cnt_q == SIL_CNT_W'(SIL_BRIEF_CYC))
    else $error("Critical error did not start brief flash");
  init_lamps_a: assert property (initializing |=> lamps.signal_yellow && lamps.busy_yellow
    && lamps.error_red)
    else $error("Initialization lamp pattern wrong");
  fwd_set_a: assert property (!initializing && !cfg.auto_direction && !cfg.set_backward
    |=> lamps.forward_green && !lamps.backward_green)
    else $error("Forward lamp wrong for set forward");
  bwd_auto_a: assert property (!initializing && cfg.auto_direction && motion_backward
    |=> lamps.backward_green)
    else $error("Backward lamp missed detected motion");
  fatal_flash_a: assert property (fatal_error && !initializing |=> lamps.error_red == $past(flash_q))
    else $error("Error lamp not flashing on fatal error");
  error_quiet_a: assert property (!initializing && !fatal_error && !brief_active |=> !lamps.error_red)
    else $error("Error lamp lit without an error");
  brief_hold_a: assert property (brief_active && !critical_error_pulse
    |=> brief_cnt_q == $past(brief_cnt_q) - 1'b1)
    else $error("Brief error window not counting down");
  brief_idle_a: assert property (!brief_active && !critical_error_pulse |=> !brief_active)
    else $error("Brief error window opened without a critical error");
  status_low_a: assert property (!initializing && !green_cond |=> !status_out)
    else $error("Status output high without green condition");
  green_lamp_a: assert property (lamps.signal_green == status_out)
    else $error("Green lamp and status output disagree");
  yellow_lamp_a: assert property (lamps.signal_yellow == (signal_colour == SIL_LAMP_YELLOW))
    else $error("Yellow lamp disagrees with signal colour");
  green_only_a: assert property (signal_colour == SIL_LAMP_GREEN |-> $past(green_cond && !initializing))
    else $error("Green shown without green condition");
  vel_limit_a: assert property (cfg.limit_control_enable && vel_out && !initializing
    |=> lamps.signal_red)
    else $error("Velocity out of range not shown red");
  rate_limit_a: assert property (cfg.limit_control_enable && rate_out && !initializing
    |=> lamps.signal_red)
    else $error("Rate out of range not shown red");
  init_status_a: assert property (initializing |=> !status_out)
    else $error("Status output high during initialization");
  init_dir_a: assert property (initializing |=> !lamps.forward_green && !lamps.backward_green)
    else $error("Direction lamp lit during initialization");
  busy_idle_a: assert property (!initializing && !standby && !busy_steady |=> !lamps.busy_yellow)
    else $error("Busy lamp lit while idle");
  fwd_auto_a: assert property (!initializing && cfg.auto_direction && motion_forward
    |=> lamps.forward_green)
    else $error("Forward lamp missed detected motion");
  fwd_auto_off_a: assert property (!initializing && cfg.auto_direction && !motion_forward
    |=> !lamps.forward_green)
    else $error("Forward lamp lit without detected motion");
  bwd_set_a: assert property (!initializing && !cfg.auto_direction && cfg.set_backward
    |=> lamps.backward_green && !lamps.forward_green)
    else $error("Backward lamp wrong for set backward");
  bwd_auto_off_a: assert property (!initializing && cfg.auto_direction && !motion_backward
    |=> !lamps.backward_green)
    else $error("Backward lamp lit without detected motion");

  // ****************************************************************
  // Covers
  // ****************************************************************
  // Scenarios the bench is meant to reach at least once
  green_seen_c: cover property (signal_colour == SIL_LAMP_GREEN ##1 signal_colour == SIL_LAMP_YELLOW);
  standby_seen_c: cover property (standby_sync_q && lamps.busy_yellow);
  brief_seen_c: cover property (critical_error_pulse ##1 brief_active);
  init_seen_c: cover property (initializing ##1 lamps.error_red);
  limit_seen_c: cover property (limit_fail ##1 lamps.signal_red);

endmodule : sil_status_indicator

// ===== dv/sil_plant_model.sv
// Plant side model: external standby switch feeding the instrument
`timescale 1ns/1ps

// ****************************************************************
// Standby switch
// ****************************************************************
module sil_plant_model (
  input wire logic standby_req,
  output logic standby_pin
);
  initial begin
    standby_pin = 1'b0;
  end

  // Switch is not tied to the clock: lands mid-cycle to exercise the synchroniser
  always @(standby_req) begin
    standby_pin <= #1.7 standby_req;
  end
endmodule : sil_plant_model

// ===== dv/sil_status_indicator_tb.sv
// Testbench for the status indicator lamp driver
`timescale 1ns/1ps

module sil_status_indicator_tb;
  import sil_pkg::*;
  typedef struct packed {
    logic [15:0] v;
    logic [15:0] r;
    logic [2:0] vqm;
    logic [5:0] mode;
    logic [3:0] bz;
    sil_colour_e c;
    logic [2:0] bfk;
  } sil_row_s;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  sil_meas_s meas = '0;
  sil_cfg_s cfg = '0;
  logic cmd_active = 1'b0, calibrating = 1'b0, simulating = 1'b0, offline_measuring = 1'b0;
  logic standby_cmd = 1'b0, standby_req = 1'b0, standby_pin, initializing = 1'b0;
  logic motion_forward = 1'b0, motion_backward = 1'b0;
  logic fatal_error = 1'b0, critical_error_pulse = 1'b0;
  sil_lamps_s lamps;
  sil_colour_e signal_colour;
  logic status_out;
  int failures = 0;
  int n_checks = 0;
  sil_row_s rows[17];

  always #2.5 sys_clk = ~sys_clk;

  sil_plant_model plant_u (.standby_req(standby_req), .standby_pin(standby_pin));

  sil_status_indicator dut_u (.sys_clk(sys_clk), .reset(reset), .meas(meas), .cfg(cfg),
    .cmd_active(cmd_active), .calibrating(calibrating), .simulating(simulating),
    .offline_measuring(offline_measuring), .standby_cmd(standby_cmd), .standby_pin(standby_pin),
    .fatal_error(fatal_error), .critical_error_pulse(critical_error_pulse), .initializing(initializing),
    .motion_forward(motion_forward), .motion_backward(motion_backward), .lamps(lamps),
    .signal_colour(signal_colour), .status_out(status_out));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    rows = '{
      '{16'h00c8, 16'h0000, 3'h7, 6'h00, 4'h0, SIL_LAMP_GREEN, 3'h2},
      '{16'h0032, 16'h0000, 3'h7, 6'h00, 4'h0, SIL_LAMP_YELLOW, 3'h2},
      '{16'h0064, 16'h0000, 3'h7, 6'h00, 4'h0, SIL_LAMP_GREEN, 3'h2},
      '{16'h00c8, 16'h0000, 3'h0, 6'h00, 4'h0, SIL_LAMP_RED, 3'h2},
      '{16'h00c8, 16'h0009, 3'h7, 6'h20, 4'h0, SIL_LAMP_RED, 3'h2},
      '{16'h00c8, 16'h000a, 3'h7, 6'h20, 4'h0, SIL_LAMP_GREEN, 3'h2},
      '{16'h0032, 16'h0009, 3'h4, 6'h20, 4'h0, SIL_LAMP_RED, 3'h2},
      '{16'h03e9, 16'h0000, 3'h7, 6'h10, 4'h0, SIL_LAMP_RED, 3'h2},
      '{16'h03e8, 16'h0000, 3'h7, 6'h10, 4'h0, SIL_LAMP_GREEN, 3'h2},
      '{16'h00c8, 16'h0000, 3'h7, 6'h04, 4'h0, SIL_LAMP_GREEN, 3'h1},
      '{16'h00c8, 16'h0000, 3'h7, 6'h0a, 4'h0, SIL_LAMP_GREEN, 3'h2},
      '{16'h00c8, 16'h0000, 3'h7, 6'h09, 4'h0, SIL_LAMP_GREEN, 3'h1},
      '{16'h00c8, 16'h0000, 3'h7, 6'h08, 4'h0, SIL_LAMP_GREEN, 3'h0},
      '{16'h0032, 16'h0000, 3'h4, 6'h00, 4'h8, SIL_LAMP_YELLOW, 3'h6},
      '{16'h00c8, 16'h0000, 3'h7, 6'h00, 4'h4, SIL_LAMP_GREEN, 3'h6},
      '{16'h00c8, 16'h0000, 3'h7, 6'h00, 4'h2, SIL_LAMP_GREEN, 3'h6},
      '{16'h00c8, 16'h0000, 3'h7, 6'h00, 4'h1, SIL_LAMP_GREEN, 3'h6}};
    cfg.minimum_velocity_threshold = 16'h0064;
    cfg.minimum_rate = 16'h000a;
    cfg.velocity_low = 16'h000a;
    cfg.velocity_high = 16'h03e8;
    cfg.rate_high = 16'hffff;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check({lamps, signal_colour, status_out}, 10'h084);
    $display("reset test done");
    @(posedge sys_clk);
    reset <= 1'b0;
    // Table rows; expected lamps are rebuilt from colour, busy and direction columns
    foreach (rows[i]) begin
      @(posedge sys_clk);
      meas <= {rows[i].vqm, rows[i].v, rows[i].r};
      {cfg.rate_monitor_enable, cfg.limit_control_enable} <= rows[i].mode[5:4];
      {cfg.auto_direction, cfg.set_backward} <= rows[i].mode[3:2];
      {motion_forward, motion_backward} <= rows[i].mode[1:0];
      {cmd_active, calibrating, simulating, offline_measuring} <= rows[i].bz;
      @(posedge sys_clk);
      @(negedge sys_clk);
      check({lamps, signal_colour, status_out}, {rows[i].c == SIL_LAMP_GREEN, rows[i].c == SIL_LAMP_YELLOW,
        rows[i].c == SIL_LAMP_RED, rows[i].bfk[2], 1'b0, rows[i].bfk[1:0], rows[i].c,
        rows[i].c == SIL_LAMP_GREEN});
      $display("row %0d done", i);
    end
    // Initialisation masks the green row and the busy input
    @(posedge sys_clk);
    initializing <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check({lamps, signal_colour, status_out}, 10'h166);
    $display("init test done");
    // Standby turns steady busy into flashing, still in its dark phase this early
    @(posedge sys_clk);
    initializing <= 1'b0;
    standby_req <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check({lamps, signal_colour, status_out}, 10'h253);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    check({9'h000, lamps.busy_yellow}, 10'h000);
    @(posedge sys_clk);
    standby_req <= 1'b0;
    standby_cmd <= 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    check({9'h000, lamps.busy_yellow}, 10'h000);
    @(posedge sys_clk);
    standby_cmd <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    check({9'h000, lamps.busy_yellow}, 10'h001);
    $display("standby test done");
    // Errors stay dark this early: the shared flasher starts in its dark half
    @(posedge sys_clk);
    fatal_error <= 1'b1;
    critical_error_pulse <= 1'b1;
    @(posedge sys_clk);
    critical_error_pulse <= 1'b0;
    @(negedge sys_clk);
    check({9'h000, lamps.error_red}, 10'h000);
    @(posedge sys_clk);
    initializing <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check({9'h000, lamps.error_red}, 10'h001);
    $display("error test done");
    // Mid-run reset clears at once; the first edge after release shows live values
    @(posedge sys_clk);
    reset <= 1'b1;
    @(negedge sys_clk);
    check({lamps, signal_colour, status_out}, 10'h084);
    @(posedge sys_clk);
    reset <= 1'b0;
    initializing <= 1'b0;
    fatal_error <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check({lamps, signal_colour, status_out}, 10'h253);
    $display("midrun reset test done");
    conclude();
  end
endmodule : sil_status_indicator_tb
